// [design/adccr_defs.svh]
`ifndef ADCCR_DEFS_SVH
`define ADCCR_DEFS_SVH

// register byte offsets on the bus
`define ADCCR_OFS_STATUS_CONTROL 12'h000
`define ADCCR_OFS_RESULT_HIGH    12'h004
`define ADCCR_OFS_RESULT_LOW     12'h008
`define ADCCR_OFS_PIN_ENABLE     12'h00C
`define ADCCR_OFS_CONTROL        12'h010

// status/control field positions
`define ADCCR_SC_DONE_BIT   7
`define ADCCR_SC_IE_BIT     6
`define ADCCR_SC_CONT_BIT   5
`define ADCCR_SC_CH_MSB     4

// control field positions
`define ADCCR_C_EIGHT_BIT   6
`define ADCCR_C_JUSTIFY_BIT 5
`define ADCCR_C_SIGNED_BIT  4
`define ADCCR_C_PRS_MSB     3

// reset values
`define ADCCR_RST_SC   8'h1F
`define ADCCR_RST_PE   8'h00
`define ADCCR_RST_CTRL 8'h00

// channel codes
`define ADCCR_CH_LAST_PIN 5'h07
`define ADCCR_CH_REF_HIGH 5'h1E
`define ADCCR_CH_REF_LOW  5'h1F

// converter clock periods per conversion
`define ADCCR_CONV_CLKS 5'd10

`endif

// [design/adccr_pkg.sv]
`default_nettype none

package adccr_pkg;

    // conversion sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } adccr_state_e;

    // software view of status/control low bits
    typedef struct packed {
        logic       done_irq_enable;
        logic       continuous_mode_bit;
        logic [4:0] channel_select;
    } adccr_sc_s;

    // separate converter control register
    typedef struct packed {
        logic       eight_bit_select;
        logic       justify_select;
        logic       signed_select;
        logic [3:0] clock_prescale;
    } adccr_ctrl_s;

    // formatted result pair
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } adccr_result_s;

endpackage

`default_nettype wire

// [design/adccr_top.sv]
// Behaviour
// [RULE1] status/control write clears flag, drops irq, restarts conversion
// [RULE2] done flag is bit 7, read-only, set at every conversion end
// [RULE3] reading either result register clears the done flag
// [RULE4] irq asserted on completion when enable bit 6 set
// [RULE5] irq stays high while done flag set, drops when cleared
// [RULE6] reset clears any pending converter irq
// [RULE7] continuous bit 5: conversions back to back, results refreshed
// [RULE8] continuous clear: exactly one conversion per status/control write
// [RULE9] channel bits 4:0, codes 00-07 pick inputs zero to seven
// [RULE10] codes 08-1D and 1F convert low reference, 1E high reference
// [RULE11] left ten-bit: data 9-2 in high 7-0, data 1-0 in low 7-6
// [RULE12] right ten-bit: data 9-8 in high 1-0, data 7-0 in low
// [RULE13] justification follows justify bit of the control register
// [RULE14] eight-bit: result in high 7-0, low reads zero
// [RULE15] ten-bit: six unused result bits read zero
// [RULE16] result registers are read-only, writes ignored
// [RULE17] pin-enable write aborts conversion, starts none
// [RULE18] disabled selected pin converts low reference, all-zero data
// [RULE19] pin-enable register holds one enable bit per input 7-0
// [RULE20] signed select only acts under left justification
// [RULE21] signed: offset coding, inverted msb
// [RULE22] converter clock is bus clock divided by (prescale+1)*2
// [RULE23] completion wins over a clearing write or read in same cycle
// [RULE24] conversion length in converter clocks is a constant

`include "adccr_defs.svh"

`default_nettype none

module adccr_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // conversion core
    output logic      [4:0]  mux_select,
    output logic             conv_active,
    output logic             sample_strobe,
    input  wire logic [9:0]  sample_data,
    // converter interrupt
    output logic             done_irq
);

    //------------------------------------------------------------
    // decode helpers
    //------------------------------------------------------------

    // true when the address hits the given offset
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // effective channel after pin gating
    function automatic logic [4:0] eff_chan(input logic [4:0] code,
                                            input logic [7:0] pe);
        eff_chan = `ADCCR_CH_REF_LOW;
        if (code <= `ADCCR_CH_LAST_PIN) begin
            if (pe[code[2:0]]) begin // [RULE9] [RULE18] [RULE19]
                eff_chan = code;
            end
        end else if (code == `ADCCR_CH_REF_HIGH) begin // [RULE10]
            eff_chan = code;
        end
    endfunction

    // place raw data into high/low registers
    function automatic adccr_pkg::adccr_result_s fmt(
            input logic [9:0]          d,
            input adccr_pkg::adccr_ctrl_s c);
        fmt = '0;
        if (c.eight_bit_select) begin
            fmt.high = d[9:2]; // [RULE14]
        end else if (!c.justify_select) begin
            fmt.high = d[9:2]; // [RULE11]
            fmt.low  = {d[1:0], 6'h00}; // [RULE15]
        end else begin
            fmt.high = {6'h00, d[9:8]}; // [RULE12] [RULE15]
            fmt.low  = d[7:0];
        end
        if (c.signed_select && !c.justify_select) begin
            fmt.high[7] = ~fmt.high[7]; // [RULE20] [RULE21]
        end
    endfunction

    //------------------------------------------------------------
    // storage
    //------------------------------------------------------------

    adccr_pkg::adccr_sc_s     sc_ff;
    adccr_pkg::adccr_ctrl_s   ctrl_ff;
    adccr_pkg::adccr_result_s res_ff;
    adccr_pkg::adccr_state_e  state_ff;
    logic [7:0]               pe_ff;
    logic                     done_flag_ff;
    logic [4:0]               div_cnt_ff;
    logic [4:0]               conv_cnt_ff;
    logic [4:0]               chan_ff;
    logic [31:0]              rdata_ff;
    logic                     rd_skip_ff;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic wr_sc;
    logic wr_pe;
    logic wr_ctrl;
    logic rd_res;
    logic mapped;
    logic tick;
    logic conv_done;
    logic [9:0] raw;

    //------------------------------------------------------------
    // apb strobes
    //------------------------------------------------------------

    // phase and register select
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign mapped  = hit(paddr, `ADCCR_OFS_STATUS_CONTROL)
                  || hit(paddr, `ADCCR_OFS_RESULT_HIGH)
                  || hit(paddr, `ADCCR_OFS_RESULT_LOW)
                  || hit(paddr, `ADCCR_OFS_PIN_ENABLE)
                  || hit(paddr, `ADCCR_OFS_CONTROL);
    assign wr_sc   = wr && hit(paddr, `ADCCR_OFS_STATUS_CONTROL);
    assign wr_pe   = wr && hit(paddr, `ADCCR_OFS_PIN_ENABLE);
    assign wr_ctrl = wr && hit(paddr, `ADCCR_OFS_CONTROL);
    assign rd_res  = rd && (hit(paddr, `ADCCR_OFS_RESULT_HIGH)
                         || hit(paddr, `ADCCR_OFS_RESULT_LOW));

    // zero-wait slave, error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = rdata_ff;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff   <= 32'h0000_0000;
            rd_skip_ff <= 1'b0;
        end else if (setup) begin
            rd_skip_ff <= conv_done; // fresh result not yet seen
            rdata_ff   <= 32'h0000_0000;
            if (hit(paddr, `ADCCR_OFS_STATUS_CONTROL)) begin
                rdata_ff[7:0] <= {done_flag_ff, sc_ff};
            end
            if (hit(paddr, `ADCCR_OFS_RESULT_HIGH)) begin
                rdata_ff[7:0] <= res_ff.high;
            end
            if (hit(paddr, `ADCCR_OFS_RESULT_LOW)) begin
                rdata_ff[7:0] <= res_ff.low;
            end
            if (hit(paddr, `ADCCR_OFS_PIN_ENABLE)) begin
                rdata_ff[7:0] <= pe_ff;
            end
            if (hit(paddr, `ADCCR_OFS_CONTROL)) begin
                rdata_ff[6:0] <= ctrl_ff;
            end
        end
    end

    //------------------------------------------------------------
    // software registers
    //------------------------------------------------------------

    // status/control writable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_ff <= 7'(`ADCCR_RST_SC);
        end else if (wr_sc) begin
            sc_ff <= pwdata[`ADCCR_SC_IE_BIT:0];
        end
    end

    // pin enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_ff <= `ADCCR_RST_PE;
        end else if (wr_pe) begin
            pe_ff <= pwdata[7:0]; // [RULE19]
        end
    end

    // converter control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 7'(`ADCCR_RST_CTRL);
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata[`ADCCR_C_EIGHT_BIT:0];
        end
    end

    //------------------------------------------------------------
    // conversion sequencer
    //------------------------------------------------------------

    // converter clock enable from prescaler
    assign tick = (state_ff == adccr_pkg::ST_CONV)
               && (div_cnt_ff == {ctrl_ff.clock_prescale, 1'b1});
    assign conv_done = tick
               && (conv_cnt_ff == `ADCCR_CONV_CLKS - 5'd1); // [RULE24]

    // prescale divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 5'h00;
        end else if (wr_sc || state_ff != adccr_pkg::ST_CONV || tick) begin
            div_cnt_ff <= 5'h00; // [RULE22]
        end else begin
            div_cnt_ff <= div_cnt_ff + 5'd1;
        end
    end

    // converter clock count within a conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_ff <= 5'h00;
        end else if (wr_sc || conv_done
                     || state_ff != adccr_pkg::ST_CONV) begin
            conv_cnt_ff <= 5'h00;
        end else if (tick) begin
            conv_cnt_ff <= conv_cnt_ff + 5'd1;
        end
    end

    // run / stop control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= adccr_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                adccr_pkg::ST_IDLE: begin
                    if (wr_sc) begin
                        state_ff <= adccr_pkg::ST_CONV; // [RULE1]
                    end
                end
                adccr_pkg::ST_CONV: begin
                    if (wr_pe) begin
                        state_ff <= adccr_pkg::ST_IDLE; // [RULE17]
                    end else if (conv_done && !wr_sc
                                 && !sc_ff.continuous_mode_bit) begin
                        state_ff <= adccr_pkg::ST_IDLE; // [RULE8]
                    end
                end
                default: begin
                    state_ff <= adccr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // channel captured at each conversion start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_ff <= `ADCCR_CH_REF_LOW;
        end else if (wr_sc) begin
            chan_ff <= eff_chan(pwdata[`ADCCR_SC_CH_MSB:0], pe_ff);
        end else if (conv_done) begin
            chan_ff <= eff_chan(sc_ff.channel_select, pe_ff); // [RULE7]
        end
    end

    // reference inputs give fixed codes
    always_comb begin
        raw = sample_data;
        if (chan_ff == `ADCCR_CH_REF_LOW) begin
            raw = 10'h000; // [RULE10] [RULE18]
        end else if (chan_ff == `ADCCR_CH_REF_HIGH) begin
            raw = 10'h3FF;
        end
    end

    // result capture, read-only to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_ff <= 16'h0000;
        end else if (conv_done) begin
            res_ff <= fmt(raw, ctrl_ff); // [RULE7] [RULE13] [RULE16]
        end
    end

    // done flag, completion wins over clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_ff <= 1'b0; // [RULE6]
        end else if (conv_done) begin
            done_flag_ff <= 1'b1; // [RULE2] [RULE23]
        end else if (wr_sc || (rd_res && !rd_skip_ff)) begin
            done_flag_ff <= 1'b0; // [RULE1] [RULE3]
        end
    end

    // core side outputs
    assign mux_select    = chan_ff;
    assign conv_active   = (state_ff == adccr_pkg::ST_CONV);
    assign sample_strobe = conv_done;
    assign done_irq      = done_flag_ff // [RULE4] [RULE5]
                        && sc_ff.done_irq_enable;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------

    a_sc_wr_clear: assert property ( // [RULE1]
        @(posedge pclk) disable iff (!presetn)
        wr_sc && !conv_done |=> !done_flag_ff && !done_irq
            && state_ff == adccr_pkg::ST_CONV)
        else $error("status write did not clear and restart");

    a_done_sets: assert property ( // [RULE2] [RULE23]
        @(posedge pclk) disable iff (!presetn)
        conv_done |=> done_flag_ff && rdata_ff[31:8] == 24'h00_0000)
        else $error("completion did not set done flag");

    a_rd_clear: assert property ( // [RULE3]
        @(posedge pclk) disable iff (!presetn)
        rd_res && !rd_skip_ff && !conv_done |=> !done_flag_ff)
        else $error("result read did not clear flag");

    a_irq_on_done: assert property ( // [RULE4]
        @(posedge pclk) disable iff (!presetn)
        conv_done && sc_ff.done_irq_enable && !wr_sc
        |=> done_irq && done_flag_ff)
        else $error("irq missing at completion");

    a_irq_tracks: assert property ( // [RULE5]
        @(posedge pclk) disable iff (!presetn)
        $fell(done_flag_ff) |-> !done_irq)
        else $error("irq outlived done flag");

    a_cont_again: assert property ( // [RULE7]
        @(posedge pclk) disable iff (!presetn)
        conv_done && sc_ff.continuous_mode_bit && !wr_pe
        |=> conv_active && conv_cnt_ff == 5'h00)
        else $error("continuous mode did not restart");

    a_single_stop: assert property ( // [RULE8]
        @(posedge pclk) disable iff (!presetn)
        conv_done && !sc_ff.continuous_mode_bit && !wr_sc
        |=> !conv_active ##1 (!conv_active || $past(wr_sc)))
        else $error("single mode converted again");

    a_pe_abort: assert property ( // [RULE17]
        @(posedge pclk) disable iff (!presetn)
        wr_pe |=> !conv_active && !sample_strobe)
        else $error("pin enable write did not abort");

    a_pin_off_zero: assert property ( // [RULE18]
        @(posedge pclk) disable iff (!presetn)
        conv_done && chan_ff == `ADCCR_CH_REF_LOW
            && !ctrl_ff.signed_select |=> res_ff == 16'h0000)
        else $error("low reference gave nonzero result");

    a_eight_low0: assert property ( // [RULE14]
        @(posedge pclk) disable iff (!presetn)
        conv_done && ctrl_ff.eight_bit_select |=> res_ff.low == 8'h00)
        else $error("eight-bit low register not zero");

    a_result_ro: assert property ( // [RULE16]
        @(posedge pclk) disable iff (!presetn)
        wr && !conv_done |=> $stable(res_ff))
        else $error("write changed a result register");

endmodule // adccr_top

`default_nettype wire

// [verification/adccr_core_model.sv]
`default_nettype none

module adccr_core_model (
    // clock
    input  wire logic       pclk,
    // converter side
    input  wire logic [4:0] mux_select,
    input  wire logic       conv_active,
    output logic      [9:0] sample_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] level;

    // analog level of the selected input
    always_comb begin
        case (mux_select)
            5'h1e:   level = 10'h3ff;
            5'h1f:   level = 10'h000;
            default: level = {mux_select[2:0], 7'h4b};
        endcase
    end

    // data only valid while converting, scrambled otherwise
    initial sample_data = 10'h2aa;
    always @(posedge pclk) begin
        sample_data <= conv_active ? level : ~sample_data;
    end
endmodule // adccr_core_model

`default_nettype wire

// [verification/testbench.sv]
`include "adccr_defs.svh"

`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_SC = `ADCCR_OFS_STATUS_CONTROL;
    localparam logic [11:0] A_RH = `ADCCR_OFS_RESULT_HIGH;
    localparam logic [11:0] A_RL = `ADCCR_OFS_RESULT_LOW;
    localparam logic [11:0] A_PE = `ADCCR_OFS_PIN_ENABLE;
    localparam logic [11:0] A_C  = `ADCCR_OFS_CONTROL;

    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, conv_active, sample_strobe, done_irq;
    logic [4:0]  mux_select;
    logic [9:0]  sample_data, v;
    int          fail_count, n_tests, n0, n1;
    logic [7:0]  cfg [6] = '{8'h20, 8'h40, 8'h60, 8'h10, 8'h30, 8'h50};
    logic [4:0]  chs [3] = '{5'h05, 5'h1e, 5'h1f};
    logic [9:0]  lv [3]  = '{10'h2cb, 10'h3ff, 10'h000};

    adccr_top u_adccr_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mux_select(mux_select),
        .conv_active(conv_active), .sample_strobe(sample_strobe),
        .sample_data(sample_data), .done_irq(done_irq)
    );

    adccr_core_model u_adccr_core_model (
        .pclk(pclk), .mux_select(mux_select),
        .conv_active(conv_active), .sample_data(sample_data)
    );

    // 200 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, holds until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // poll status until the done flag shows
    task automatic wait_done();
        int i;
        i = 0;
        do begin
            apb(1'b0, A_SC, 32'h0);
            i++;
        end while (rd[7] !== 1'b1 && i < 100);
        chk(rd[7], 1'b1);
    endtask

    task automatic conv(input logic [7:0] c, input logic [7:0] sc);
        apb(1'b1, A_C, {24'h0, c});
        apb(1'b1, A_SC, {24'h0, sc});
        wait_done();
    endtask

    // expected high/low pair from raw data and control
    function automatic logic [15:0] fmt(input logic [9:0] x,
                                        input logic [7:0] c);
        logic [7:0] s;
        s = {c[4] & ~c[5], 7'h00};
        if (c[6])
            fmt = {x[9:2] ^ s, 8'h00};
        else if (c[5])
            fmt = {6'h00, x};
        else
            fmt = {x[9:2] ^ s, x[1:0], 6'h00};
    endfunction

    task automatic res(input logic [9:0] x, input logic [7:0] c);
        logic [15:0] e;
        e = fmt(x, c);
        apb(1'b0, A_RH, 32'h0);
        chk(rd, {24'h0, e[15:8]});
        apb(1'b0, A_RL, 32'h0);
        chk(rd, {24'h0, e[7:0]});
    endtask

    // count cycles from a status write to the sample strobe
    task automatic measure(input logic [7:0] c, output int n);
        apb(1'b1, A_C, {24'h0, c});
        apb(1'b1, A_SC, 32'h01);
        n = 0;
        while (sample_strobe !== 1'b1 && n < 500) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(sample_strobe, 1'b1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_count = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_SC, 32'h0);
        chk(rd, 32'h1f);
        apb(1'b0, A_PE, 32'h0);
        chk(rd, 32'h0);
        chk(done_irq, 1'b0);
        apb(1'b1, 12'h014, 32'h55);
        chk(err, 1'b1);
        // every channel code, ten-bit left
        apb(1'b1, A_PE, 32'hff);
        for (int ch = 0; ch < 32; ch++) begin
            v = (ch < 8) ? {3'(ch), 7'h4b} : (ch == 30) ? 10'h3ff : 10'h0;
            conv(8'h00, {3'b010, 5'(ch)});
            chk(done_irq, 1'b1);
            chk(mux_select, (ch < 8 || ch == 30) ? 5'(ch) : 5'h1f);
            res(v, 8'h00);
            apb(1'b0, A_SC, 32'h0);
            chk(rd, {27'h2, 5'(ch)});
            chk(done_irq, 1'b0);
        end
        // justification, width and sign formats
        foreach (cfg[k]) begin
            foreach (chs[j]) begin
                conv(cfg[k], {3'b010, chs[j]});
                res(lv[j], cfg[k]);
            end
        end
        apb(1'b1, A_RH, 32'h55);
        apb(1'b1, A_RL, 32'h55);
        res(10'h0, 8'h50);
        // restart clears flag and irq, single shot stays idle
        conv(8'h00, 8'h42);
        apb(1'b1, A_SC, 32'h42);
        chk(done_irq, 1'b0);
        apb(1'b0, A_SC, 32'h0);
        chk(rd, 32'h42);
        wait_done();
        res(10'h14b, 8'h00);
        repeat (80) @(posedge pclk);
        #1;
        chk(conv_active, 1'b0);
        apb(1'b0, A_SC, 32'h0);
        chk(rd, 32'h42);
        // pin-enable write aborts
        apb(1'b1, A_SC, 32'h43);
        apb(1'b1, A_PE, 32'hff);
        @(posedge pclk);
        #1;
        chk(conv_active, 1'b0);
        repeat (80) @(posedge pclk);
        apb(1'b0, A_SC, 32'h0);
        chk(rd, 32'h43);
        // disabled pin converts low reference
        apb(1'b1, A_PE, 32'hfe);
        conv(8'h00, 8'h40);
        res(10'h0, 8'h00);
        chk(mux_select, 5'h1f);
        // continuous without irq enable
        apb(1'b1, A_PE, 32'hff);
        conv(8'h00, 8'h22);
        chk(done_irq, 1'b0);
        res(10'h14b, 8'h00);
        wait_done();
        res(10'h14b, 8'h00);
        // reset drops a pending request
        conv(8'h00, 8'h42);
        chk(done_irq, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk(done_irq, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_SC, 32'h0);
        chk(rd, 32'h1f);
        // converter clock prescale
        measure(8'h00, n0);
        measure(8'h01, n1);
        chk(32'(n1 - n0), 32'd20);
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
